// >>> rtl/smc_boot_seq.sv
// reboot sequencer: standby first, then boot count with interfaces held in reset
`default_nettype none
module smc_boot_seq (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // requests
    input wire logic sw_req,
    input wire logic pin_req,
    input wire logic sys_active,
    // sequencing outputs
    output logic force_standby,
    output logic load_defaults,
    output logic if_reset,
    output logic boot_done,
    output logic busy
);
    import smc_pkg::*;

    smc_boot_st_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            SMC_BS_IDLE: begin
                if (sw_req || pin_req) begin
                    if (sys_active) begin
                        st_d = SMC_BS_STBY;
                    end else begin
                        st_d = SMC_BS_BOOT;
                        cnt_d = SMC_BOOT_CNT;
                    end
                end
            end
            SMC_BS_STBY: begin
                if (!sys_active) begin
                    st_d = SMC_BS_BOOT;
                    cnt_d = SMC_BOOT_CNT;
                end
            end
            SMC_BS_BOOT: begin
                cnt_d = cnt_q - SMC_CNT_LAST;
                if (cnt_q == SMC_CNT_LAST) begin
                    st_d = SMC_BS_DONE;
                end
            end
            default: begin
                st_d = SMC_BS_IDLE;
                cnt_d = SMC_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= SMC_BS_IDLE;
            cnt_q <= SMC_CNT_ZERO;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign force_standby = (st_q != SMC_BS_IDLE);
    assign load_defaults = (st_q == SMC_BS_BOOT) && (cnt_q == SMC_BOOT_CNT);
    assign if_reset = (st_q == SMC_BS_BOOT) || (st_q == SMC_BS_DONE);
    assign boot_done = (st_q == SMC_BS_DONE);
    assign busy = (st_q != SMC_BS_IDLE);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_req_active;
        (st_q == SMC_BS_IDLE) && (sw_req || pin_req) && sys_active;
    endsequence
    sequence s_boot_entry;
        $rose(load_defaults);
    endsequence

    AST_ACTIVE_GOES_STANDBY: assert property (s_req_active |=> force_standby && !if_reset)
        else $error("reboot in active mode did not hold off for standby");
    AST_STANDBY_STARTS_NOW: assert property (
        (st_q == SMC_BS_IDLE) && (sw_req || pin_req) && !sys_active |=> load_defaults)
        else $error("reboot from standby did not start at once");
    AST_NO_BOOT_WHILE_ACTIVE: assert property ((st_q == SMC_BS_STBY) && sys_active |=> !if_reset)
        else $error("boot began before standby was reached");
    AST_BOOT_ENDS: assert property (s_boot_entry |-> if_reset [*8] ##[1:300] boot_done)
        else $error("boot did not finish in the expected time");
endmodule
`default_nettype wire

// >>> rtl/smc_mode_ctrl.sv
// sensor mode control register with self-test, reboot, oversampling and auto-sleep
`default_nettype none
// Notes on behaviour
// - self-test bit set adds a fixed shift to every axis output sample.
// - reboot bit set makes the boot logic reload every register field except the reboot bit with defaults.
// - reboot is accepted both in standby and in active mode.
// - reboot forces standby first; boot begins only once standby is reached.
// - rising edge on the reset pin starts the same reboot.
// - every reboot also resets the serial interface logic.
// - reboot bit clears by hardware when boot is finished.
// - sleep oversampling field with sleep rate sets sleep mode oversampling.
// - auto-sleep bit enables automatic sleep and wake transitions.
// - wake oversampling field with output rate sets wake mode oversampling.
// - field codes 00 normal, 01 low-noise low-power, 10 high-res, 11 low-power.
// - with auto-sleep on, each sleep/wake change flushes fifo and clears debounce.
module smc_mode_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port from serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // external reset pin
    input wire logic rst_pin,
    // system mode
    input wire logic sys_active,
    input wire logic sleep_state,
    input wire logic [2:0] output_rate_select,
    input wire logic [1:0] aslp_rate,
    // sample path
    input wire smc_pkg::smc_axes_t axes_in,
    output smc_pkg::smc_axes_t axes_out,
    // control outputs
    output logic accel_selftest_enable,
    output logic auto_sleep_en,
    output smc_pkg::smc_osr_sel_t osr_sel,
    output logic fifo_flush,
    output logic debounce_clear,
    output logic force_standby,
    output logic if_reset,
    output logic boot_busy
);
    import smc_pkg::*;

    smc_ctrl_t ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    smc_axes_t axes_q, axes_d;
    smc_osr_sel_t osr_q, osr_d;
    logic flush_q, flush_d;
    logic sleep_prev_q;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic pin_edge;
    logic load_defaults;
    logic boot_done;
    logic hit;
    smc_ctrl_t wr_val;

    smc_boot_seq u_boot (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sw_req(ctrl_q.reboot),
        .pin_req(pin_edge),
        .sys_active(sys_active),
        .force_standby(force_standby),
        .load_defaults(load_defaults),
        .if_reset(if_reset),
        .boot_done(boot_done),
        .busy(boot_busy)
    );

    // reset pin synchroniser and edge detect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= rst_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    assign pin_edge = pin_s2_q && !pin_s3_q;

    // register file
    assign hit = (reg_addr == SMC_REG_ADDR);
    assign wr_val = smc_ctrl_t'(reg_wdata);

    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        if (reg_wr && hit && !if_reset) begin
            ctrl_d = wr_val;
            ctrl_d.reboot = ctrl_q.reboot || wr_val.reboot;
        end
        if (load_defaults) begin
            ctrl_d = smc_ctrl_t'(SMC_REG_RESET);
            ctrl_d.reboot = ctrl_q.reboot;
        end
        if (boot_done) begin
            ctrl_d.reboot = 1'b0;
        end
        ctrl_d.unused = SMC_UNUSED_VAL;
        if (reg_rd && hit && !if_reset) begin
            rdata_d = ctrl_q;
        end else if (reg_rd) begin
            rdata_d = SMC_RDATA_NONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= smc_ctrl_t'(SMC_REG_RESET);
            rdata_q <= SMC_RDATA_NONE;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // sample path, oversampling select and auto-sleep transition handling
    always_comb begin
        axes_d = axes_in;
        if (ctrl_q.selftest) begin
            axes_d.x = axes_in.x + SMC_ST_SHIFT;
            axes_d.y = axes_in.y + SMC_ST_SHIFT;
            axes_d.z = axes_in.z + SMC_ST_SHIFT;
        end
        if (sleep_state) begin
            osr_d.mode = ctrl_q.smods;
            osr_d.rate = {1'b0, aslp_rate};
        end else begin
            osr_d.mode = ctrl_q.mods;
            osr_d.rate = output_rate_select;
        end
        flush_d = ctrl_q.slpe && (sleep_state != sleep_prev_q);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            axes_q <= '0;
            osr_q <= '0;
            flush_q <= 1'b0;
            sleep_prev_q <= 1'b0;
        end else begin
            axes_q <= axes_d;
            osr_q <= osr_d;
            flush_q <= flush_d;
            sleep_prev_q <= sleep_state;
        end
    end

    assign reg_rdata = rdata_q;
    assign axes_out = axes_q;
    assign osr_sel = osr_q;
    assign fifo_flush = flush_q;
    assign debounce_clear = flush_q;
    assign accel_selftest_enable = ctrl_q.selftest;
    assign auto_sleep_en = ctrl_q.slpe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_pin_pulse;
        !pin_s2_q ##1 pin_s2_q;
    endsequence

    AST_SELFTEST_SHIFT: assert property (ctrl_q.selftest |=>
        axes_out.x == $past(axes_in.x) + SMC_ST_SHIFT)
        else $error("self-test shift missing on x axis");
    AST_SELFTEST_OFF: assert property (!ctrl_q.selftest |=> axes_out == $past(axes_in))
        else $error("samples altered with self-test off");
    AST_SW_REBOOT_STARTS: assert property ($rose(ctrl_q.reboot) && !boot_busy |=> boot_busy)
        else $error("reboot request not taken");
    AST_DEFAULTS_LOADED: assert property (load_defaults |=>
        ctrl_q.mods == SMC_OSR_NORMAL && ctrl_q.smods == SMC_OSR_NORMAL &&
        !ctrl_q.slpe && !ctrl_q.selftest &&
        ctrl_q.reboot == $past(ctrl_q.reboot))
        else $error("defaults not reloaded during boot");
    AST_PIN_REBOOT: assert property (s_pin_pulse ##0 !boot_busy |=> boot_busy)
        else $error("reset pin pulse did not start reboot");
    AST_IF_WRITE_BLOCKED: assert property (if_reset |=> $stable(ctrl_q.mods) || $past(load_defaults))
        else $error("register changed while interfaces held in reset");
    AST_REBOOT_CLEARS: assert property (boot_done |=> !ctrl_q.reboot ##1 !boot_busy)
        else $error("reboot bit not cleared after boot");
    AST_SLEEP_OSR: assert property (sleep_state |=> osr_sel.mode == $past(ctrl_q.smods))
        else $error("sleep oversampling not selected");
    AST_WAKE_OSR: assert property (!sleep_state |=>
        osr_sel.mode == $past(ctrl_q.mods) && osr_sel.rate == $past(output_rate_select))
        else $error("wake oversampling not selected");
    AST_FLUSH_ON_CHANGE: assert property (ctrl_q.slpe && $changed(sleep_state) |=>
        fifo_flush && debounce_clear)
        else $error("mode change did not flush fifo");
    AST_NO_FLUSH_WHEN_OFF: assert property (!$past(ctrl_q.slpe) |-> !fifo_flush)
        else $error("flush with auto-sleep disabled");
    AST_UNUSED_ZERO: assert property (reg_rd && hit && !if_reset |=> !reg_rdata[5])
        else $error("unused bit read back nonzero");
    AST_SELFTEST_YZ: assert property (ctrl_q.selftest |=>
        axes_out.y == $past(axes_in.y) + SMC_ST_SHIFT &&
        axes_out.z == $past(axes_in.z) + SMC_ST_SHIFT)
        else $error("self-test shift missing on y or z axis");
    AST_WRITE_STORES: assert property (reg_wr && hit && !if_reset |=>
        ctrl_q.smods == $past(wr_val.smods) && ctrl_q.mods == $past(wr_val.mods) &&
        ctrl_q.slpe == $past(wr_val.slpe) && ctrl_q.selftest == $past(wr_val.selftest))
        else $error("register write not stored");
    AST_REBOOT_HELD: assert property (ctrl_q.reboot && !boot_done |=> ctrl_q.reboot)
        else $error("reboot bit cleared before boot end");
    AST_MISS_READS_ZERO: assert property (reg_rd && !(hit && !if_reset) |=>
        reg_rdata == SMC_RDATA_NONE)
        else $error("refused read returned data");
    AST_NO_FLUSH_STEADY: assert property (!$changed(sleep_state) |=> !fifo_flush)
        else $error("flush without a mode change");
    AST_SLEEP_RATE: assert property (sleep_state |=>
        osr_sel.rate == {1'b0, $past(aslp_rate)})
        else $error("sleep rate not selected");
    AST_BOOT_IN_STANDBY: assert property (if_reset |-> force_standby)
        else $error("boot ran outside standby");
    AST_PIN_EDGE_ONCE: assert property (pin_edge |=> !pin_edge)
        else $error("reset pin pulse seen twice");
endmodule
`default_nettype wire

// >>> rtl/smc_pkg.sv
// shared constants and types for the sensor mode control register
`default_nettype none
package smc_pkg;
    localparam logic [7:0] SMC_REG_ADDR = 8'h2B;
    localparam logic [7:0] SMC_REG_RESET = 8'h00;
    localparam logic [7:0] SMC_RDATA_NONE = 8'h00;
    localparam logic SMC_UNUSED_VAL = 1'b0;
    localparam int SMC_CLK_PERIOD_NS = 4;
    localparam int SMC_BOOT_TIME_NS = 1000;
    localparam int SMC_BOOT_CYC = (SMC_BOOT_TIME_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
    localparam logic [7:0] SMC_BOOT_CNT = 8'(SMC_BOOT_CYC);
    localparam logic [7:0] SMC_CNT_LAST = 8'h01;
    localparam logic [7:0] SMC_CNT_ZERO = 8'h00;
    localparam int SMC_AXIS_W = 14;
    localparam logic [SMC_AXIS_W-1:0] SMC_ST_SHIFT = 14'h0100;

    typedef enum logic [1:0] {
        SMC_OSR_NORMAL = 2'h0,
        SMC_OSR_LNLP = 2'h1,
        SMC_OSR_HIRES = 2'h2,
        SMC_OSR_LOWPWR = 2'h3
    } smc_osr_t;

    typedef struct packed {
        logic selftest;
        logic reboot;
        logic unused;
        smc_osr_t smods;
        logic slpe;
        smc_osr_t mods;
    } smc_ctrl_t;

    typedef struct packed {
        smc_osr_t mode;
        logic [2:0] rate;
    } smc_osr_sel_t;

    typedef struct packed {
        logic [SMC_AXIS_W-1:0] x;
        logic [SMC_AXIS_W-1:0] y;
        logic [SMC_AXIS_W-1:0] z;
    } smc_axes_t;

    typedef enum logic [1:0] {
        SMC_BS_IDLE = 2'b00,
        SMC_BS_STBY = 2'b01,
        SMC_BS_BOOT = 2'b11,
        SMC_BS_DONE = 2'b10
    } smc_boot_st_t;
endpackage
`default_nettype wire

// >>> tb/sensor_mode_control_reg_test.sv
// self-checking bench for the sensor mode control register
`default_nettype none
module sensor_mode_control_reg_test;
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;
    logic clk_sys, rstn, reg_wr, reg_rd, rst_pin, sys_active, sleep_state;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] output_rate_select;
    logic [1:0] aslp_rate, code;
    smc_axes_t axes_in, axes_out;
    smc_osr_sel_t osr_sel;
    logic accel_selftest_enable, auto_sleep_en, fifo_flush, debounce_clear;
    logic force_standby, if_reset, boot_busy, ok;
    int num_errors = 0;
    int tests_run = 0;
    int ir_cnt = 0;
    int fl_cnt = 0;
    smc_mode_ctrl i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rst_pin(rst_pin), .sys_active(sys_active), .sleep_state(sleep_state),
        .output_rate_select(output_rate_select), .aslp_rate(aslp_rate),
        .axes_in(axes_in), .axes_out(axes_out),
        .accel_selftest_enable(accel_selftest_enable), .auto_sleep_en(auto_sleep_en),
        .osr_sel(osr_sel), .fifo_flush(fifo_flush), .debounce_clear(debounce_clear),
        .force_standby(force_standby), .if_reset(if_reset), .boot_busy(boot_busy));
    smc_host_model i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .boot_busy(boot_busy));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        ir_cnt <= ir_cnt + int'(if_reset === 1'b1);
        fl_cnt <= fl_cnt + int'(fifo_flush === 1'b1) + int'(debounce_clear === 1'b1);
    end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic boot_wait();
        i_host.settle(ok);
        if (ok !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
    endtask
    initial begin
        rstn = 1'b0;
        rst_pin = 1'b0;
        sys_active = 1'b0;
        sleep_state = 1'b0;
        output_rate_select = 3'h5;
        aslp_rate = 2'h2;
        axes_in = {14'h0001, 14'h0002, 14'h3FFF};
        step(6);
        rstn <= 1'b1;
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, SMC_REG_RESET);
        i_host.wr(SMC_REG_ADDR, 8'hBB);
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, 8'h9B);
        chk({accel_selftest_enable, auto_sleep_en}, 2'h2);
        chk(axes_out, {14'h0101, 14'h0102, 14'h00FF});
        i_host.wr(8'h2C, 8'h00);
        i_host.rd(8'h2A, d);
        chk(d, SMC_RDATA_NONE);
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, 8'h9B);
        $display("end of register access test");
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            i_host.wr(SMC_REG_ADDR, {3'h0, ~code, 1'b1, code});
            step(3);
            chk(osr_sel, {code, output_rate_select});
            chk(auto_sleep_en, 1'b1);
            sleep_state <= 1'b1;
            step(3);
            chk(osr_sel, {~code, 1'b0, aslp_rate});
            sleep_state <= 1'b0;
            step(3);
        end
        chk(fl_cnt, 16);
        i_host.wr(SMC_REG_ADDR, 8'h00);
        sleep_state <= 1'b1;
        step(3);
        sleep_state <= 1'b0;
        step(3);
        chk(fl_cnt, 16);
        chk(axes_out, axes_in);
        $display("end of oversampling and auto-sleep test");
        i_host.wr(SMC_REG_ADDR, 8'hDF);
        step(4);
        chk(boot_busy, 1'b1);
        i_host.wr(SMC_REG_ADDR, 8'h03);
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, SMC_RDATA_NONE);
        boot_wait();
        chk(ir_cnt, SMC_BOOT_CYC + 1);
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, SMC_REG_RESET);
        $display("end of standby reboot test");
        step(1);
        sys_active <= 1'b1;
        i_host.wr(SMC_REG_ADDR, 8'h40);
        step(20);
        chk({force_standby, if_reset}, 2'h2);
        sys_active <= 1'b0;
        boot_wait();
        chk(ir_cnt, 2 * (SMC_BOOT_CYC + 1));
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, SMC_REG_RESET);
        $display("end of active reboot test");
        i_host.wr(SMC_REG_ADDR, 8'h84);
        rst_pin <= 1'b1;
        step(2);
        rst_pin <= 1'b0;
        step(6);
        chk(boot_busy, 1'b1);
        boot_wait();
        chk(ir_cnt, 3 * (SMC_BOOT_CYC + 1));
        i_host.rd(SMC_REG_ADDR, d);
        chk(d, SMC_REG_RESET);
        $display("end of pin reboot test");
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> tb/smc_host_model.sv
// host model driving the register strobe port
`default_nettype none
module smc_host_model #(
    parameter int BOOT_WAIT_CYC = 300
) (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // reboot status
    input wire logic boot_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, never a stale copy
    task automatic release_bus();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        release_bus();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        release_bus();
        #1;
        d = reg_rdata;
    endtask
    // shortened settling wait, bus kept quiet throughout
    task automatic settle(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 2000 && ok !== 1'b1; i++) begin
            @(posedge clk_sys);
            ok = (boot_busy === 1'b0);
        end
        repeat (BOOT_WAIT_CYC) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
